// >>> pkg/nand_host_pkg.sv
// shared constants, types and timing for the nand pin host controller
package nand_host_pkg;
  // array geometry
  localparam int BLOCKS_TOTAL = 2048;
  localparam int BLOCKS_PER_PLANE = 1024;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCK_W = 11;
  localparam int PAGE_W = 6;
  localparam int COL_W = 12;
  localparam int COUNT_W = 12;
  localparam int ADDR_CYCLES = 5;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3F;
  localparam logic [7:0] MARK_GOOD = 8'hFF;
  // command bytes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  // timing at 50 ns per clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int ARRAY_READ_TIME_NS = 25000;
  localparam int PROGRAM_TIME_NS = 300000;
  localparam int ERASE_TIME_NS = 3000000;
  localparam int ARRAY_READ_CYCLES = ARRAY_READ_TIME_NS / CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_FACTOR = 4;
  localparam int BUSY_ASSERT_CYCLES = 2;
  localparam int TIMER_W = 24;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_ERASE = 2'h2,
    OP_CHECK = 2'h3
  } op_e;

  typedef enum logic [1:0] {
    PH_CMD = 2'h0,
    PH_ADDR = 2'h1,
    PH_DATA = 2'h2,
    PH_CONF = 2'h3
  } phase_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WR_LOW = 3'h1,
    ST_WR_HIGH = 3'h3,
    ST_WAIT_WB = 3'h2,
    ST_WAIT_RB = 3'h6,
    ST_RD_LOW = 3'h7,
    ST_RD_HIGH = 3'h5,
    ST_FINISH = 3'h4
  } state_e;

  typedef struct packed {
    op_e op;
    logic [BLOCK_W-1:0] block;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] column;
    logic [COUNT_W-1:0] count;
  } req_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1, wp_n: 1'b0};

  typedef struct packed {
    logic refused;
    logic timeout;
    logic bad_block;
  } result_s;
endpackage

// >>> logic/nand_host_ctrl.sv
// host controller driving a nand device through its strobes and shared io bus
`timescale 1ns/1ns

module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter bit BUS16 = 1'b0,
  parameter int NUM_BLOCKS = BLOCKS_TOTAL,
  parameter int PAGES = PAGES_PER_BLOCK,
  parameter int PROG_LIMIT = TIMEOUT_FACTOR * PROGRAM_CYCLES,
  parameter int ERASE_LIMIT = TIMEOUT_FACTOR * ERASE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request port
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  // program data in
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  // read data out
  output logic rd_valid,
  output logic [15:0] rd_data,
  // completion
  output logic done,
  output result_s result,
  // device pins
  output pins_s pins,
  input wire logic rb_in,
  input wire logic [15:0] io_in,
  output logic [15:0] io_out,
  output logic io_low_oe,
  output logic io_high_oe
);
  if (NUM_BLOCKS != BLOCKS_TOTAL || PAGES != PAGES_PER_BLOCK || NUM_BLOCKS != 2 * BLOCKS_PER_PLANE) begin : g_geom_check
    $error("geometry parameters do not match the addressing logic");
  end
  if (PROG_LIMIT >= (1 << TIMER_W) || ERASE_LIMIT >= (1 << TIMER_W)) begin : g_timer_check
    $error("busy timeout does not fit the timer");
  end

  localparam int DATA_W = BUS16 ? 16 : 8;
  localparam logic [TIMER_W-1:0] READ_LIMIT_T = TIMER_W'(ARRAY_READ_CYCLES);
  localparam logic [TIMER_W-1:0] PROG_LIMIT_T = TIMER_W'(PROG_LIMIT);
  localparam logic [TIMER_W-1:0] ERASE_LIMIT_T = TIMER_W'(ERASE_LIMIT);
  localparam logic [TIMER_W-1:0] WB_LIMIT_T = TIMER_W'(BUSY_ASSERT_CYCLES);

  state_e state_q;
  phase_e phase_q;
  req_s req_q;
  pins_s pins_q;
  logic [2:0] addr_idx_q;
  logic [COUNT_W-1:0] cnt_q;
  logic [TIMER_W-1:0] timer_q;
  logic [15:0] io_q;
  logic low_oe_q;
  logic high_oe_q;
  logic scan_pass_q;
  logic scan_bad_q;
  logic [NUM_BLOCKS-1:0] bad_q;
  logic [NUM_BLOCKS-1:0] checked_q;
  result_s result_q;
  logic done_q;
  logic rd_valid_q;
  logic [15:0] rd_data_q;
  logic need_data;
  logic modify_op;
  logic refuse;
  logic [TIMER_W-1:0] busy_limit;
  logic mark_bad;

  // address byte for one of the five cycles, row = {block, page}
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input req_s r);
    logic [16:0] row;
    row = {r.block, r.page};
    unique case (idx)
      3'h0: addr_byte = r.column[7:0];
      3'h1: addr_byte = BUS16 ? {5'h00, r.column[10:8]} : {4'h0, r.column[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction

  // more than half of the marking bits read as zero
  function automatic logic majority_zero(input logic [15:0] d);
    int zeros;
    zeros = 0;
    for (int i = 0; i < DATA_W; i++) begin
      zeros = zeros + (d[i] ? 0 : 1);
    end
    majority_zero = (zeros > DATA_W / 2);
  endfunction

  function automatic logic [7:0] go_cmd(input op_e op);
    unique case (op)
      OP_PROGRAM: go_cmd = CMD_PROG_GO;
      OP_ERASE: go_cmd = CMD_ERASE_GO;
      default: go_cmd = CMD_READ_GO;
    endcase
  endfunction

  function automatic logic [7:0] setup_cmd(input op_e op);
    unique case (op)
      OP_PROGRAM: setup_cmd = CMD_PROG_SETUP;
      OP_ERASE: setup_cmd = CMD_ERASE_SETUP;
      default: setup_cmd = CMD_READ_SETUP;
    endcase
  endfunction

  assign modify_op = (req.op == OP_PROGRAM) || (req.op == OP_ERASE);
  assign refuse = modify_op && (!checked_q[req.block] || bad_q[req.block]);
  assign need_data = (req_q.op == OP_PROGRAM) &&
                     (((phase_q == PH_ADDR) && (addr_idx_q == 3'(ADDR_CYCLES - 1)) && (req_q.count != '0)) ||
                      ((phase_q == PH_DATA) && (cnt_q != '0)));
  assign mark_bad = majority_zero(io_in);

  always_comb begin
    unique case (req_q.op)
      OP_PROGRAM: busy_limit = PROG_LIMIT_T;
      OP_ERASE: busy_limit = ERASE_LIMIT_T;
      default: busy_limit = READ_LIMIT_T;
    endcase
  end

  assign req_ready = (state_q == ST_IDLE);
  assign wr_ready = (state_q == ST_WR_HIGH) && need_data;

  // sequencing of bus cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      phase_q <= PH_CMD;
      req_q <= '0;
      addr_idx_q <= 3'h0;
      cnt_q <= '0;
      timer_q <= '0;
      scan_pass_q <= 1'b0;
      scan_bad_q <= 1'b0;
      result_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            req_q <= req;
            result_q <= '0;
            scan_pass_q <= 1'b0;
            scan_bad_q <= 1'b0;
            if (req.op == OP_CHECK) begin
              req_q.page <= '0;
              req_q.column <= '0;
              req_q.count <= COUNT_W'(1);
            end
            if (req.op == OP_ERASE) begin
              req_q.column <= '0;
              req_q.page <= '0;
            end
            phase_q <= PH_CMD;
            if (refuse) begin
              result_q.refused <= 1'b1;
              state_q <= ST_FINISH;
            end else begin
              state_q <= ST_WR_LOW;
            end
          end
        end
        ST_WR_LOW: state_q <= ST_WR_HIGH;
        ST_WR_HIGH: begin
          unique case (phase_q)
            PH_CMD: begin
              phase_q <= PH_ADDR;
              addr_idx_q <= 3'h0;
              state_q <= ST_WR_LOW;
            end
            PH_ADDR: begin
              if (addr_idx_q != 3'(ADDR_CYCLES - 1)) begin
                addr_idx_q <= addr_idx_q + 3'h1;
                state_q <= ST_WR_LOW;
              end else if (req_q.op == OP_PROGRAM) begin
                cnt_q <= req_q.count;
                if (req_q.count == '0) begin
                  phase_q <= PH_CONF;
                  state_q <= ST_WR_LOW;
                end else if (wr_valid) begin
                  phase_q <= PH_DATA;
                  cnt_q <= req_q.count - COUNT_W'(1);
                  state_q <= ST_WR_LOW;
                end
              end else begin
                phase_q <= PH_CONF;
                state_q <= ST_WR_LOW;
              end
            end
            PH_DATA: begin
              if (cnt_q == '0) begin
                phase_q <= PH_CONF;
                state_q <= ST_WR_LOW;
              end else if (wr_valid) begin
                cnt_q <= cnt_q - COUNT_W'(1);
                state_q <= ST_WR_LOW;
              end
            end
            PH_CONF: begin
              timer_q <= '0;
              state_q <= ST_WAIT_WB;
            end
          endcase
        end
        ST_WAIT_WB: begin
          timer_q <= timer_q + TIMER_W'(1);
          if (timer_q == WB_LIMIT_T) begin
            timer_q <= '0;
            state_q <= ST_WAIT_RB;
          end
        end
        ST_WAIT_RB: begin
          timer_q <= timer_q + TIMER_W'(1);
          if (rb_in) begin
            cnt_q <= req_q.count;
            if (req_q.op == OP_READ || req_q.op == OP_CHECK) begin
              state_q <= (req_q.count == '0) ? ST_FINISH : ST_RD_LOW;
            end else begin
              state_q <= ST_FINISH;
            end
          end else if (timer_q == busy_limit) begin
            result_q.timeout <= 1'b1;
            state_q <= ST_FINISH;
          end
        end
        ST_RD_LOW: begin
          cnt_q <= cnt_q - COUNT_W'(1);
          if (req_q.op == OP_CHECK) begin
            scan_bad_q <= scan_bad_q | mark_bad;
          end
          state_q <= ST_RD_HIGH;
        end
        ST_RD_HIGH: begin
          if (cnt_q != '0) begin
            state_q <= ST_RD_LOW;
          end else if (req_q.op == OP_CHECK && !scan_pass_q) begin
            scan_pass_q <= 1'b1;
            req_q.page <= LAST_PAGE;
            req_q.count <= COUNT_W'(1);
            phase_q <= PH_CMD;
            state_q <= ST_WR_LOW;
          end else begin
            result_q.bad_block <= (req_q.op == OP_CHECK) && scan_bad_q;
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pin levels, registered for clean strobes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins_q <= PINS_IDLE;
      io_q <= '0;
      low_oe_q <= 1'b0;
      high_oe_q <= 1'b0;
    end else begin
      pins_q.ce_n <= !((state_q != ST_IDLE && state_q != ST_FINISH) || (state_q == ST_IDLE && req_valid && !refuse));
      pins_q.read_strobe_n <= !(state_q == ST_RD_HIGH && cnt_q != '0) &&
                              !(state_q == ST_WAIT_RB && rb_in && req_q.count != '0 &&
                                (req_q.op == OP_READ || req_q.op == OP_CHECK));
      pins_q.wp_n <= (state_q == ST_IDLE) ? (req_valid && modify_op && !refuse) :
                     (state_q != ST_FINISH) && (req_q.op == OP_PROGRAM || req_q.op == OP_ERASE);
      if (state_q == ST_IDLE && req_valid && !refuse) begin
        pins_q.cle <= 1'b1;
        pins_q.ale <= 1'b0;
        pins_q.we_n <= 1'b0;
        io_q <= {8'h00, setup_cmd(req.op)};
        low_oe_q <= 1'b1;
        high_oe_q <= 1'b0;
      end else if (state_q == ST_WR_LOW) begin
        pins_q.we_n <= 1'b1;
      end else if (state_q == ST_WR_HIGH && (phase_q != PH_CONF)) begin
        if (phase_q == PH_CMD || (phase_q == PH_ADDR && addr_idx_q != 3'(ADDR_CYCLES - 1))) begin
          pins_q.cle <= 1'b0;
          pins_q.ale <= 1'b1;
          pins_q.we_n <= 1'b0;
          io_q <= {8'h00, addr_byte((phase_q == PH_CMD) ? 3'h0 : addr_idx_q + 3'h1, req_q)};
          high_oe_q <= 1'b0;
        end else if (need_data && wr_valid) begin
          pins_q.cle <= 1'b0;
          pins_q.ale <= 1'b0;
          pins_q.we_n <= 1'b0;
          io_q <= BUS16 ? wr_data : {8'h00, wr_data[7:0]};
          high_oe_q <= BUS16;
        end else if (!need_data) begin
          pins_q.cle <= 1'b1;
          pins_q.ale <= 1'b0;
          pins_q.we_n <= 1'b0;
          io_q <= {8'h00, go_cmd(req_q.op)};
          high_oe_q <= 1'b0;
        end
      end else if (state_q == ST_WR_HIGH || state_q == ST_WAIT_WB) begin
        pins_q.cle <= 1'b0;
        pins_q.ale <= 1'b0;
        low_oe_q <= (state_q == ST_WR_HIGH);
        high_oe_q <= (state_q == ST_WR_HIGH) && high_oe_q;
      end else if (state_q == ST_RD_HIGH && cnt_q == '0 && req_q.op == OP_CHECK && !scan_pass_q) begin
        // second marking pass must open with its own read setup byte
        pins_q.cle <= 1'b1;
        pins_q.ale <= 1'b0;
        pins_q.we_n <= 1'b0;
        io_q <= {8'h00, CMD_READ_SETUP};
        low_oe_q <= 1'b1;
        high_oe_q <= 1'b0;
      end else if (state_q == ST_WAIT_RB || state_q == ST_RD_LOW || state_q == ST_RD_HIGH) begin
        low_oe_q <= 1'b0;
        high_oe_q <= 1'b0;
      end else begin
        pins_q.cle <= 1'b0;
        pins_q.ale <= 1'b0;
        pins_q.we_n <= 1'b1;
        low_oe_q <= 1'b0;
        high_oe_q <= 1'b0;
      end
    end
  end

  // bad block table filled by check requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bad_q <= '0;
      checked_q <= '0;
    end else if (state_q == ST_RD_HIGH && cnt_q == '0 && req_q.op == OP_CHECK && scan_pass_q) begin
      checked_q[req_q.block] <= 1'b1;
      bad_q[req_q.block] <= scan_bad_q;
    end
  end

  // user side outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      done_q <= 1'b0;
    end else begin
      rd_valid_q <= (state_q == ST_RD_LOW) && (req_q.op == OP_READ);
      if (state_q == ST_RD_LOW) begin
        rd_data_q <= BUS16 ? io_in : {8'h00, io_in[7:0]};
      end
      done_q <= (state_q == ST_FINISH);
    end
  end

  assign pins = pins_q;
  assign io_out = io_q;
  assign io_low_oe = low_oe_q;
  assign io_high_oe = high_oe_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign done = done_q;
  assign result = result_q;
endmodule

// >>> testbench/nand_host_chk.sv
// concurrent checks on the nand host controller ports
`timescale 1ns/1ns
module nand_host_chk
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire req_s req,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [15:0] wr_data,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic done,
  input wire result_s result,
  // device side
  input wire pins_s pins,
  input wire logic rb_in,
  input wire logic [15:0] io_in,
  input wire logic [15:0] io_out,
  input wire logic io_low_oe,
  input wire logic io_high_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] addr_cnt_q;
  // address write strobes counted since the last command byte
  always_ff @(posedge clk_sys) begin
    if (rst || pins.cle)
      addr_cnt_q <= 3'h0;
    else if (pins.ale && $rose(pins.we_n))
      addr_cnt_q <= addr_cnt_q + 3'h1;
  end
  sequence s_we_rise;
    !pins.we_n ##1 pins.we_n;
  endsequence
  sequence s_strobe_fall;
    pins.read_strobe_n ##1 !pins.read_strobe_n;
  endsequence
  a_standby_idle: assert property (req_ready |-> pins.ce_n)
    else $error("select low while idle");
  a_cmd_frame: assert property (pins.cle |-> !pins.ale && !pins.ce_n && pins.read_strobe_n)
    else $error("command frame wrong");
  a_latch_hold: assert property (s_we_rise |-> io_low_oe && $stable(io_out) && !pins.ce_n)
    else $error("bus moved at write strobe");
  a_high_quiet: assert property ((pins.cle || pins.ale) |-> !io_high_oe)
    else $error("high byte driven in command or address");
  a_read_released: assert property (!pins.read_strobe_n |-> !io_low_oe && !io_high_oe && pins.we_n)
    else $error("host drives bus while reading");
  a_ready_first: assert property (s_strobe_fall |-> rb_in && $past(rb_in))
    else $error("read strobe while busy");
  a_five_addr: assert property ($fell(pins.ale) |-> addr_cnt_q == 3'h5)
    else $error("address cycle count wrong");
  a_modify_protect: assert property (pins.cle && !pins.we_n && (io_out[7:0] == CMD_PROG_GO ||
    io_out[7:0] == CMD_ERASE_GO) |-> pins.wp_n)
    else $error("write protect low at modify command");
  a_data_slot: assert property (rd_valid |-> !$past(pins.read_strobe_n) || !$past(pins.read_strobe_n, 2))
    else $error("read word without read strobe");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_ready: assert property (done && !result.refused && !result.timeout |-> rb_in)
    else $error("done while device busy");
endmodule

// >>> testbench/nand_dev_model.sv
// behavioural nand device answering the host controller pins
`timescale 1ns/1ns
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int RD_T = 20,
  parameter int PROG_T = 30,
  parameter int ERASE_T = 60,
  parameter int BAD_BLK = 5
) (
  // host side
  input wire logic clk_sys,
  input wire pins_s pins,
  input wire logic [7:0] bus_lvl,
  input wire logic slow,
  // device drivers and observation
  output logic busy_low,
  output logic dev_oe,
  output logic [7:0] dev_val,
  output logic [39:0] addr_seen,
  output logic wp_fault
);
  logic [7:0] mem [int];
  logic [7:0] pend [$];
  logic [7:0] last_q = 8'h00;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  int busy_q = 0;
  int row_q = 0;
  int col_q = 0;
  function automatic logic [7:0] pat(input int blk, input int pg, input int col);
    if (col == 0)
      return (blk == BAD_BLK && pg == 63) ? 8'h00 : 8'hFF;
    return 8'(blk ^ (pg << 2) ^ col ^ (col >> 8));
  endfunction
  // row is block times 64 plus page, lowest block bit picks the plane
  function automatic logic [7:0] rd_byte(input int row, input int col);
    return mem.exists(row * 4096 + col) ? mem[row * 4096 + col] : pat(row >> 6, row & 63, col);
  endfunction
  assign dev_oe = !pins.ce_n && !pins.read_strobe_n;
  assign dev_val = dev_oe ? rd_byte(row_q, col_q) : ~last_q;
  assign busy_low = busy_q != 0;
  initial begin
    addr_seen = '0;
    wp_fault = 1'b0;
  end
  always @(posedge clk_sys) begin
    we_q <= pins.we_n;
    re_q <= pins.read_strobe_n;
    if (busy_q != 0)
      busy_q <= busy_q - 1;
    if (dev_oe)
      last_q <= dev_val;
    if (pins.read_strobe_n && !re_q && !pins.ce_n)
      col_q <= col_q + 1;
    if (pins.we_n && !we_q && !pins.ce_n) begin
      if (pins.cle && bus_lvl == CMD_READ_GO) begin
        row_q <= int'(addr_seen[32:16]);
        col_q <= int'(addr_seen[11:0]);
        busy_q <= RD_T;
      end else if (pins.cle && (bus_lvl == CMD_PROG_GO || bus_lvl == CMD_ERASE_GO)) begin
        if (!pins.wp_n) begin
          wp_fault <= 1'b1;
        end else begin
          busy_q <= slow ? 400 : (bus_lvl == CMD_PROG_GO ? PROG_T : ERASE_T);
          foreach (pend[i]) mem[int'(addr_seen[32:16]) * 4096 + int'(addr_seen[11:0]) + i] = pend[i];
        end
        pend.delete();
      end else if (pins.cle) begin
        pend.delete();
      end else if (pins.ale) begin
        addr_seen <= {bus_lvl, addr_seen[39:8]};
      end else begin
        pend.push_back(bus_lvl);
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// self-checking bench for the nand host controller against the device model
`timescale 1ns/1ns
module tb;
  import nand_host_pkg::*;
  localparam int BAD_BLK = 5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  req_s req = '0;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic slow = 1'b0;
  logic req_ready, wr_ready, rd_valid, done, rb_in, io_low_oe, io_high_oe, busy_low, dev_oe, wp_fault;
  logic [15:0] rd_data, io_out, io_in;
  logic [7:0] bus_lvl, dev_val;
  logic [39:0] addr_seen;
  result_s result, res;
  pins_s pins;
  logic rd_valid16, done16, busy16, oe16_lo, wp_fault16;
  logic [15:0] rd_data16, io_out16;
  logic [7:0] bus16, dev_val16;
  logic [39:0] addr16;
  pins_s pins16;
  logic [15:0] rdq16 [$];
  logic [15:0] rdq [$];
  logic [15:0] wq [$];
  int wi = 0;
  int n_fail = 0;
  int compares = 0;
  int seed = 50007;
  int b, p, c, n;

  always #25 clk_sys = ~clk_sys;
  assign bus_lvl = io_low_oe ? io_out[7:0] : dev_val;
  assign io_in = {~bus_lvl, bus_lvl};
  assign rb_in = !busy_low;
  assign bus16 = oe16_lo ? io_out16[7:0] : dev_val16;

  nand_host_ctrl #(.BUS16(1'b0), .PROG_LIMIT(50), .ERASE_LIMIT(100)) nand_host_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .result(result),
    .pins(pins), .rb_in(rb_in), .io_in(io_in), .io_out(io_out), .io_low_oe(io_low_oe), .io_high_oe(io_high_oe));
  nand_dev_model #(.BAD_BLK(BAD_BLK)) nand_dev_model_i (.clk_sys(clk_sys), .pins(pins), .bus_lvl(bus_lvl),
    .slow(slow), .busy_low(busy_low), .dev_oe(dev_oe), .dev_val(dev_val), .addr_seen(addr_seen), .wp_fault(wp_fault));
  // same stimulus into a x16 controller with its own device model, running in lockstep
  nand_host_ctrl #(.BUS16(1'b1), .PROG_LIMIT(50), .ERASE_LIMIT(100)) nand_host_ctrl_x16_i (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(), .req(req), .wr_valid(wr_valid),
    .wr_ready(), .wr_data(wr_data), .rd_valid(rd_valid16), .rd_data(rd_data16), .done(done16), .result(),
    .pins(pins16), .rb_in(!busy16), .io_in({bus16, bus16}), .io_out(io_out16), .io_low_oe(oe16_lo),
    .io_high_oe());
  nand_dev_model #(.BAD_BLK(BAD_BLK)) nand_dev_model_x16_i (.clk_sys(clk_sys), .pins(pins16), .bus_lvl(bus16),
    .slow(slow), .busy_low(busy16), .dev_oe(), .dev_val(dev_val16), .addr_seen(addr16),
    .wp_fault(wp_fault16));

  function automatic logic [7:0] pat(input int blk, input int pg, input int col);
    if (col == 0)
      return (blk == BAD_BLK && pg == 63) ? 8'h00 : 8'hFF;
    return 8'(blk ^ (pg << 2) ^ col ^ (col >> 8));
  endfunction
  // five address bytes, first byte lowest
  function automatic logic [39:0] addr_bytes(input int blk, input int pg, input int col);
    logic [16:0] row;
    row = 17'(blk * 64 + pg);
    return {7'h00, row, 4'h0, 12'(col)};
  endfunction
  // x16 column is eleven bits, upper five lines of the second cycle low
  function automatic logic [39:0] addr_x16(input int blk, input int pg, input int col);
    logic [16:0] row;
    row = 17'(blk * 64 + pg);
    return {7'h00, row, 5'h00, 11'(col)};
  endfunction

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic run_op(input op_e op, input int blk, input int pg, input int col, input int cnt);
    int k;
    rdq.delete();
    rdq16.delete();
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: op, block: 11'(blk), page: 6'(pg), column: 12'(col), count: 12'(cnt)};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (done !== 1'b1 && k < 2000);
    check("done", done, 1'b1);
    check("x16 done", done16, 1'b1);
    res = result;
  endtask

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);
    if (rd_valid16 === 1'b1)
      rdq16.push_back(rd_data16);
    if (wr_valid && wr_ready === 1'b1)
      wi = wi + 1;
    if (!(wr_valid && wr_ready !== 1'b1)) begin
      wr_valid <= wi < wq.size() && $random(seed) % 4 != 0;
      wr_data <= wi < wq.size() ? wq[wi] : 16'h0000;
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("idle pins", pins, PINS_IDLE);
    check("idle result", result, 3'h0);
    $display("test reset finished");
    run_op(OP_PROGRAM, 7, 0, 0, 1);
    check("unchecked refused", res.refused, 1'b1);
    run_op(OP_CHECK, BAD_BLK, 0, 0, 1);
    check("bad mark", res.bad_block, 1'b1);
    check("last page addr", addr_seen, addr_bytes(BAD_BLK, 63, 0));
    run_op(OP_PROGRAM, BAD_BLK, 0, 0, 1);
    check("bad refused", res.refused, 1'b1);
    run_op(OP_CHECK, 9, 0, 0, 1);
    check("good mark", res.bad_block, 1'b0);
    $display("test marking finished");
    for (int i = 0; i < 5; i++) begin
      b = i == 0 ? 2047 : ($random(seed) & 2047);
      p = i == 0 ? 63 : ($random(seed) & 63);
      c = i == 0 ? 2110 : ($random(seed) & 2047);
      n = i == 0 ? 2 : 1 + ($random(seed) & 3);
      run_op(OP_READ, b, p, c, n);
      check("read addr", addr_seen, addr_bytes(b, p, c));
      check("read count", rdq.size(), n);
      foreach (rdq[j]) check("read data", rdq[j], {8'h00, pat(b, p, c + j)});
      check("x16 addr", addr16, addr_x16(b, p, c));
      check("x16 count", rdq16.size(), n);
      foreach (rdq16[j]) check("x16 data", rdq16[j], {2{pat(b, p, (c & 2047) + j)}});
    end
    $display("test read finished");
    p = $random(seed) & 63;
    c = 1 + ($random(seed) & 1023);
    for (int j = 0; j < 3; j++) wq.push_back(16'($random(seed)));
    wi = 0;
    run_op(OP_PROGRAM, 9, p, c, 3);
    check("program result", res, 3'h0);
    check("program addr", addr_seen, addr_bytes(9, p, c));
    check("write protect", wp_fault, 1'b0);
    check("x16 write protect", wp_fault16, 1'b0);
    run_op(OP_READ, 9, p, c, 3);
    foreach (wq[j]) check("readback", rdq[j], {8'h00, wq[j][7:0]});
    run_op(OP_ERASE, 9, p, c, 1);
    check("erase result", res, 3'h0);
    check("erase addr", addr_seen, addr_bytes(9, 0, 0));
    $display("test modify finished");
    slow <= 1'b1;
    wi = 0;
    run_op(OP_PROGRAM, 9, 0, 1, 3);
    check("slow program", res.timeout, 1'b1);
    $display("test timeout finished");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end
endmodule

bind nand_host_ctrl nand_host_chk nand_host_chk_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
  .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .result(result), .pins(pins), .rb_in(rb_in),
  .io_in(io_in), .io_out(io_out), .io_low_oe(io_low_oe), .io_high_oe(io_high_oe));
